// >>> gpio_consts.svh
/*
 * Register indices, field positions, reset values and bus codes of the
 * port register block.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_PORT_A_PIN_LATCH 5'h00
`define IDX_PORT_B_PIN_LATCH 5'h01
`define IDX_PORT_C_PIN_LATCH 5'h02
`define IDX_PORT_D_PIN_LATCH 5'h03
`define IDX_PORT_A_DIRECTION 5'h04
`define IDX_PORT_B_DIRECTION 5'h05
`define IDX_PORT_C_DIRECTION 5'h06
`define IDX_PORT_D_DIRECTION 5'h07
`define IDX_PORT_D_PIN_CONFIG 5'h0B
`define IDX_ANALOG_PORT_INPUT 5'h0C
`define IDX_PORT_C_PIN_CONFIG 5'h0E
`define IDX_CONVERTER_STATUS_CONTROL 5'h11

// Field positions
`define CONVERTER_ENABLE_BIT 5
`define ANALOG_PORT_WIDTH 4

// Reset values
`define RST_DIRECTION 8'h00
`define RST_PIN_CONFIG 8'h00
`define RST_CONVERTER_ENABLE 1'h0

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> gpio_pkg.sv
/*
 * Types shared by the port register block.
 * Assumes gpio_consts.svh is on the include path.
 */
package gpio_pkg;
   `include "gpio_consts.svh"

   typedef logic [3:0][7:0] port_bytes_t;

   typedef struct packed {
      logic aw_held;
      logic [4:0] aw_idx;
      logic w_held;
      logic [31:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      port_bytes_t latch;
      port_bytes_t dir;
      logic [7:0] keyboard_port_pin_mode;
      logic [7:0] config_port_pin_mode;
      logic converter_enable_bit;
   } gpio_state_t;
endpackage

// >>> pin_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes pins are asynchronous to aclk; output changes only once
 * stages two and three agree.
 */
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 36
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [WIDTH-1:0] pins_async,
   output logic [WIDTH-1:0] pins_sync
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] filt;
   } sync_state_t;

   sync_state_t s_q;
   sync_state_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.s1 = pins_async;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (s_q.s2[i] == s_q.s3[i]) begin
            s_d.filt[i] = s_q.s2[i];
         end
      end
      if (!aresetn) begin
         s_d = '0;
      end
   end

   always_ff @(posedge aclk) begin
      s_q <= s_d;
   end

   assign pins_sync = s_q.filt;
endmodule
`default_nettype wire

// >>> gpio_ports.sv
/*
 * Port register block: four bidirectional byte ports, two with pin
 * mode registers, a four-pin input-only analogue-shared port and the
 * converter enable, all behind an AXI4-Lite slave.
 * Assumes pads resolve each pin from out/oe and apply pulls as told.
 */
`timescale 1ns/100ps
`default_nettype none
module gpio_ports
   import gpio_pkg::*;
#(
   parameter int ADDR_WIDTH = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_WIDTH-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_WIDTH-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [7:0] port_a_pins_in,
   output logic [7:0] port_a_pins_out,
   output logic [7:0] port_a_pins_oe,
   input wire logic [7:0] port_b_pins_in,
   output logic [7:0] port_b_pins_out,
   output logic [7:0] port_b_pins_oe,
   input wire logic [7:0] keyboard_port_pins_in,
   output logic [7:0] keyboard_port_pins_out,
   output logic [7:0] keyboard_port_pins_oe,
   output logic [7:0] keyboard_port_pullup_en,
   input wire logic [7:0] config_port_pins_in,
   output logic [7:0] config_port_pins_out,
   output logic [7:0] config_port_pins_oe,
   output logic [7:0] config_port_pullup_en,
   input wire logic [3:0] analog_shared_pins_in,
   output logic converter_enable
);
   gpio_state_t s_q;
   gpio_state_t s_d;
   logic [35:0] pins_sync;
   port_bytes_t pin_level;
   logic [3:0] analog_level;
   logic [4:0] ar_idx;
   logic ar_take;
   logic do_write;

   pin_sync #(
      .WIDTH(36)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pins_async({analog_shared_pins_in, config_port_pins_in,
                   keyboard_port_pins_in, port_b_pins_in, port_a_pins_in}),
      .pins_sync(pins_sync)
   );

   assign pin_level = pins_sync[31:0];
   assign analog_level = pins_sync[35:32];

   function automatic logic [4:0] addr_idx(input logic [ADDR_WIDTH-1:0] a);
      addr_idx = a[6:2];
   endfunction

   function automatic logic idx_mapped(input logic [4:0] idx);
      idx_mapped = (idx <= `IDX_PORT_D_DIRECTION) ||
                   (idx == `IDX_PORT_D_PIN_CONFIG) ||
                   (idx == `IDX_ANALOG_PORT_INPUT) ||
                   (idx == `IDX_PORT_C_PIN_CONFIG) ||
                   (idx == `IDX_CONVERTER_STATUS_CONTROL);
   endfunction

   // Output pins read back the latch, inputs the pin
   function automatic logic [7:0] port_read(input logic [7:0] latch,
                                            input logic [7:0] dir,
                                            input logic [7:0] pin);
      port_read = (dir & latch) | (~dir & pin);
   endfunction

   assign awready = !s_q.aw_held;
   assign wready = !s_q.w_held;
   assign arready = !s_q.rvalid;
   assign ar_take = arvalid && arready;
   assign ar_idx = addr_idx(araddr);
   assign do_write = s_q.aw_held && s_q.w_held && !s_q.bvalid;

   always_comb begin
      s_d = s_q;
      if (awvalid && awready) begin
         s_d.aw_held = 1'b1;
         s_d.aw_idx = addr_idx(awaddr);
      end
      if (wvalid && wready) begin
         s_d.w_held = 1'b1;
         s_d.w_data = wdata;
         s_d.w_lane0 = wstrb[0];
      end
      if (s_q.bvalid && bready) begin
         s_d.bvalid = 1'b0;
      end
      if (do_write) begin
         s_d.aw_held = 1'b0;
         s_d.w_held = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = idx_mapped(s_q.aw_idx) ? `RESP_OKAY : `RESP_SLVERR;
         if (s_q.w_lane0) begin
            unique case (s_q.aw_idx)
               `IDX_PORT_A_PIN_LATCH, `IDX_PORT_B_PIN_LATCH,
               `IDX_PORT_C_PIN_LATCH, `IDX_PORT_D_PIN_LATCH: begin
                  s_d.latch[s_q.aw_idx[1:0]] = s_q.w_data[7:0];
               end
               `IDX_PORT_A_DIRECTION, `IDX_PORT_B_DIRECTION,
               `IDX_PORT_C_DIRECTION, `IDX_PORT_D_DIRECTION: begin
                  s_d.dir[s_q.aw_idx[1:0]] = s_q.w_data[7:0];
               end
               `IDX_PORT_D_PIN_CONFIG: begin
                  s_d.config_port_pin_mode = s_q.w_data[7:0];
               end
               `IDX_PORT_C_PIN_CONFIG: begin
                  s_d.keyboard_port_pin_mode = s_q.w_data[7:0];
               end
               `IDX_CONVERTER_STATUS_CONTROL: begin
                  s_d.converter_enable_bit = s_q.w_data[`CONVERTER_ENABLE_BIT];
               end
               default: begin
               end
            endcase
         end
      end
      if (s_q.rvalid && rready) begin
         s_d.rvalid = 1'b0;
      end
      if (ar_take) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = 32'h0000_0000;
         s_d.rresp = idx_mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
         unique case (ar_idx)
            `IDX_PORT_A_PIN_LATCH, `IDX_PORT_B_PIN_LATCH,
            `IDX_PORT_C_PIN_LATCH, `IDX_PORT_D_PIN_LATCH: begin
               s_d.rdata[7:0] = port_read(s_q.latch[ar_idx[1:0]],
                                          s_q.dir[ar_idx[1:0]],
                                          pin_level[ar_idx[1:0]]);
            end
            `IDX_PORT_A_DIRECTION, `IDX_PORT_B_DIRECTION,
            `IDX_PORT_C_DIRECTION, `IDX_PORT_D_DIRECTION: begin
               s_d.rdata[7:0] = s_q.dir[ar_idx[1:0]];
            end
            `IDX_PORT_D_PIN_CONFIG: begin
               s_d.rdata[7:0] = s_q.config_port_pin_mode;
            end
            `IDX_ANALOG_PORT_INPUT: begin
               // Readable whatever the converter is doing
               s_d.rdata[`ANALOG_PORT_WIDTH-1:0] = analog_level;
            end
            `IDX_PORT_C_PIN_CONFIG: begin
               s_d.rdata[7:0] = s_q.keyboard_port_pin_mode;
            end
            `IDX_CONVERTER_STATUS_CONTROL: begin
               s_d.rdata[`CONVERTER_ENABLE_BIT] = s_q.converter_enable_bit;
            end
            default: begin
            end
         endcase
      end
      if (!aresetn) begin
         // Latches keep their contents through reset
         s_d.aw_held = 1'b0;
         s_d.aw_idx = 5'h00;
         s_d.w_held = 1'b0;
         s_d.w_data = 32'h0000_0000;
         s_d.w_lane0 = 1'b0;
         s_d.bvalid = 1'b0;
         s_d.bresp = `RESP_OKAY;
         s_d.rvalid = 1'b0;
         s_d.rdata = 32'h0000_0000;
         s_d.rresp = `RESP_OKAY;
         s_d.latch = s_q.latch;
         s_d.dir = {4{`RST_DIRECTION}};
         s_d.keyboard_port_pin_mode = `RST_PIN_CONFIG;
         s_d.config_port_pin_mode = `RST_PIN_CONFIG;
         s_d.converter_enable_bit = `RST_CONVERTER_ENABLE;
      end
   end

   always_ff @(posedge aclk) begin
      s_q <= s_d;
   end

   assign bvalid = s_q.bvalid;
   assign bresp = s_q.bresp;
   assign rvalid = s_q.rvalid;
   assign rdata = s_q.rdata;
   assign rresp = s_q.rresp;

   // Latch drives only when the pin is an output; masked to avoid unknowns
   assign port_a_pins_out = s_q.latch[0] & s_q.dir[0];
   assign port_a_pins_oe = s_q.dir[0];
   assign port_b_pins_out = s_q.latch[1] & s_q.dir[1];
   assign port_b_pins_oe = s_q.dir[1];

   // Mode-configurable ports; pins carry no other function
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         always_comb begin
            keyboard_port_pins_out[g] = 1'b0;
            keyboard_port_pins_oe[g] = 1'b0;
            if (s_q.dir[2][g]) begin
               keyboard_port_pins_out[g] = s_q.latch[2][g] &
                                           !s_q.keyboard_port_pin_mode[g];
               keyboard_port_pins_oe[g] = !(s_q.keyboard_port_pin_mode[g] &&
                                            s_q.latch[2][g]);
            end
         end
         always_comb begin
            config_port_pins_out[g] = 1'b0;
            config_port_pins_oe[g] = 1'b0;
            if (s_q.dir[3][g]) begin
               if (s_q.config_port_pin_mode[g]) begin
                  // Open drain: pull low or release
                  config_port_pins_out[g] = 1'b0;
                  config_port_pins_oe[g] = !s_q.latch[3][g];
               end else begin
                  config_port_pins_out[g] = s_q.latch[3][g];
                  config_port_pins_oe[g] = 1'b1;
               end
            end
         end
      end
   endgenerate

   assign keyboard_port_pullup_en = ~s_q.dir[2] & ~s_q.keyboard_port_pin_mode;
   assign config_port_pullup_en = ~s_q.dir[3] & ~s_q.config_port_pin_mode;
   // Hands the shared pins to the converter
   assign converter_enable = s_q.converter_enable_bit;

   AST_RESET_CONFIG: assert property (@(posedge aclk)
      !aresetn |=> (s_q.dir[3] == 8'h00) &&
         (config_port_pullup_en == 8'hFF) && (config_port_pins_oe == 8'h00))
      else $error("configurable port not cleared by reset");

   AST_RESET_DIRS: assert property (@(posedge aclk)
      !aresetn |=> (port_a_pins_oe == 8'h00) && (port_b_pins_oe == 8'h00) &&
         (keyboard_port_pins_oe == 8'h00))
      else $error("direction registers not cleared by reset");

   AST_RESET_MODES: assert property (@(posedge aclk)
      !aresetn |=> (keyboard_port_pullup_en == 8'hFF) && !converter_enable)
      else $error("pin mode registers not cleared by reset");

   AST_INPUT_UNDRIVEN: assert property (@(posedge aclk) disable iff (!aresetn)
      ((config_port_pins_oe & ~s_q.dir[3]) == 8'h00) &&
         ((port_a_pins_oe ^ s_q.dir[0]) == 8'h00))
      else $error("input pin driven");

   AST_OPEN_DRAIN: assert property (@(posedge aclk) disable iff (!aresetn)
      ((config_port_pins_oe & config_port_pins_out &
        s_q.config_port_pin_mode) == 8'h00) &&
         ((s_q.dir[3] & s_q.config_port_pin_mode & ~s_q.latch[3] &
           ~config_port_pins_oe) == 8'h00))
      else $error("open-drain pin drove high or failed to pull low");

   AST_PUSH_PULL: assert property (@(posedge aclk) disable iff (!aresetn)
      ((s_q.dir[3] & ~s_q.config_port_pin_mode &
        (~config_port_pins_oe | (config_port_pins_out ^ s_q.latch[3]))) == 8'h00))
      else $error("push-pull pin does not follow latch");

   AST_LATCH_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && s_q.w_lane0 && (s_q.aw_idx == `IDX_PORT_D_PIN_LATCH)
         |=> s_q.latch[3] == $past(s_q.w_data[7:0]))
      else $error("latch write lost");

   AST_READ_OUTPUT: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_take && (ar_idx == `IDX_PORT_D_PIN_LATCH) && (s_q.dir[3] == 8'hFF)
         |=> rvalid && (rdata == {24'h000000, $past(s_q.latch[3])}))
      else $error("output pin read did not return latch");

   AST_ANALOG_READ: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_take && (ar_idx == `IDX_ANALOG_PORT_INPUT)
         |=> rvalid && (rdata[31:4] == 28'h0000000) && (rresp == `RESP_OKAY))
      else $error("analogue port read malformed");

   AST_CONV_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && s_q.w_lane0 && (s_q.aw_idx == `IDX_CONVERTER_STATUS_CONTROL)
         |=> converter_enable == $past(s_q.w_data[5]))
      else $error("converter enable not written");

   AST_KEYBOARD_MODES: assert property (@(posedge aclk) disable iff (!aresetn)
      ((keyboard_port_pins_oe & keyboard_port_pins_out &
        s_q.keyboard_port_pin_mode) == 8'h00) &&
         ((s_q.dir[2] & ~s_q.keyboard_port_pin_mode & ~keyboard_port_pins_oe) == 8'h00))
      else $error("keyboard port pin mode not obeyed");

   AST_PULLUP_INPUTS: assert property (@(posedge aclk) disable iff (!aresetn)
      ((config_port_pullup_en & config_port_pins_oe) == 8'h00) &&
         ((keyboard_port_pullup_en & keyboard_port_pins_oe) == 8'h00))
      else $error("pull-up enabled on a driven pin");

   AST_DIR_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && s_q.w_lane0 && (s_q.aw_idx == `IDX_PORT_A_DIRECTION)
         |=> port_a_pins_oe == $past(s_q.w_data[7:0]))
      else $error("direction write did not set pin enables");

   AST_STROBE_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && !s_q.w_lane0 |=> $stable(s_q.dir))
      else $error("write without byte lane changed a direction");

   AST_READ_INPUT: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_take && (ar_idx == `IDX_PORT_A_PIN_LATCH) && (s_q.dir[0] == 8'h00)
         |=> rvalid && (rdata == {24'h000000, $past(pin_level[0])}))
      else $error("input pin read did not return pin level");

   AST_ANALOG_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
      ar_take && (ar_idx == `IDX_ANALOG_PORT_INPUT)
         |=> rdata[`ANALOG_PORT_WIDTH-1:0] == $past(analog_level))
      else $error("analogue port read did not return pin level");
endmodule
`default_nettype wire

// >>> board_model.sv
/*
 * Board behind the port pins: resolves each wire from the block's
 * drive, external drivers and pulls.
 * Assumes pins packed as {D, C, B, A}, one byte each.
 */
`timescale 1ns/100ps
`default_nettype none
module board_model (
   input wire logic aclk,
   input wire logic [31:0] dev_out,
   input wire logic [31:0] dev_oe,
   input wire logic [31:0] pull_up,
   input wire logic [31:0] pull_dn,
   input wire logic [31:0] ext_en,
   input wire logic [31:0] ext_val,
   output logic [31:0] pins_in
);
   logic [31:0] last_q = 32'h0;
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         if (dev_oe[i])
            pins_in[i] = dev_out[i];
         else if (ext_en[i])
            pins_in[i] = ext_val[i];
         else if (pull_up[i] || pull_dn[i])
            pins_in[i] = pull_up[i];
         else
            pins_in[i] = ~last_q[i]; // Floating wire wanders
      end
   end
   always_ff @(posedge aclk) begin
      last_q <= pins_in;
   end
endmodule
`default_nettype wire

// >>> test_parallel_port_d_g_regs.sv
/*
 * Self-checking bench of the port register block over AXI4-Lite.
 * Assumes gpio_consts.svh on the include path and board_model.sv.
 */
`timescale 1ns/100ps
`default_nettype none
`include "gpio_consts.svh"
module test_parallel_port_d_g_regs;
   typedef struct {logic [4:0] idx; logic [31:0] wd; logic [31:0] rd; logic [1:0] rsp;} row_t;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, conv_en;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] a_in, a_out, a_oe, b_in, b_out, b_oe, c_in, c_out, c_oe, c_pu;
   logic [7:0] d_in, d_out, d_oe, d_pu;
   logic [3:0] g_in = 4'h0;
   logic [31:0] ext_en = 32'h0;
   logic [31:0] ext_val = 32'h0;
   int n_errors = 0;
   int checked = 0;
   logic [4:0] rst_idx [7] = '{`IDX_PORT_A_DIRECTION, `IDX_PORT_B_DIRECTION,
      `IDX_PORT_C_DIRECTION, `IDX_PORT_D_DIRECTION, `IDX_PORT_D_PIN_CONFIG,
      `IDX_PORT_C_PIN_CONFIG, `IDX_CONVERTER_STATUS_CONTROL};
   row_t rows [9] = '{
      '{`IDX_PORT_A_DIRECTION, 32'h5A, 32'h5A, `RESP_OKAY},
      '{`IDX_PORT_B_DIRECTION, 32'hFF, 32'hFF, `RESP_OKAY},
      '{`IDX_PORT_C_DIRECTION, 32'h81, 32'h81, `RESP_OKAY},
      '{`IDX_PORT_D_DIRECTION, 32'h3C, 32'h3C, `RESP_OKAY},
      '{`IDX_PORT_D_PIN_CONFIG, 32'hC3, 32'hC3, `RESP_OKAY},
      '{`IDX_PORT_C_PIN_CONFIG, 32'h7E, 32'h7E, `RESP_OKAY},
      '{`IDX_CONVERTER_STATUS_CONTROL, 32'hFFFFFFFF, 32'h20, `RESP_OKAY},
      '{`IDX_CONVERTER_STATUS_CONTROL, 32'h0, 32'h0, `RESP_OKAY},
      '{5'h08, 32'hFF, 32'h0, `RESP_SLVERR}};

   gpio_ports gpio_ports_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .port_a_pins_in(a_in), .port_a_pins_out(a_out), .port_a_pins_oe(a_oe),
      .port_b_pins_in(b_in), .port_b_pins_out(b_out), .port_b_pins_oe(b_oe),
      .keyboard_port_pins_in(c_in), .keyboard_port_pins_out(c_out),
      .keyboard_port_pins_oe(c_oe), .keyboard_port_pullup_en(c_pu),
      .config_port_pins_in(d_in), .config_port_pins_out(d_out),
      .config_port_pins_oe(d_oe), .config_port_pullup_en(d_pu),
      .analog_shared_pins_in(g_in), .converter_enable(conv_en));

   // Port A pulled up, port B pulled down on the board
   board_model board_model_inst (.aclk(aclk), .dev_out({d_out, c_out, b_out, a_out}),
      .dev_oe({d_oe, c_oe, b_oe, a_oe}), .pull_up({d_pu, c_pu, 8'h00, 8'hFF}),
      .pull_dn(32'h0000FF00), .ext_en(ext_en), .ext_val(ext_val),
      .pins_in({d_in, c_in, b_in, a_in}));

   always #10 aclk = ~aclk;

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, seen);
         n_errors++;
      end
   endtask

   task automatic hang(input logic busy);
      if (busy) begin
         $display("ERROR bus wait expected answer seen none");
         n_errors++;
         close_out();
      end
   endtask

   task automatic do_reset;
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask

   task automatic wr(input logic [4:0] idx, input logic [31:0] d, output logic [1:0] r);
      logic a, w, b;
      a = 1'b1;
      w = 1'b1;
      b = 1'b1;
      @(posedge aclk);
      awaddr <= {1'b0, idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 200 && (a || w || b); n++) begin
         @(posedge aclk);
         if (b && !a && !w && bvalid) begin
            b = 1'b0;
            r = bresp;
            bready <= 1'b0;
         end
         if (a && awready) begin
            a = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end
      hang(a || w || b);
   endtask

   task automatic rd(input logic [4:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic a, b;
      a = 1'b1;
      b = 1'b1;
      @(posedge aclk);
      araddr <= {1'b0, idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 200 && (a || b); n++) begin
         @(posedge aclk);
         if (b && !a && rvalid) begin
            b = 1'b0;
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
         if (a && arready) begin
            a = 1'b0;
            arvalid <= 1'b0;
         end
      end
      hang(a || b);
   endtask

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] e_oe, e_out, e_pu;
      do_reset();
      foreach (rst_idx[i]) begin
         rd(rst_idx[i], d, r);
         check("reset value", d, 32'h0);
      end
      check("reset enables", {d_oe, c_oe, b_oe, a_oe}, 32'h0);
      check("reset pull-ups", {d_pu, c_pu}, 32'hFFFF);
      check("reset converter", conv_en, 32'h0);
      // Latches first, so no pin ever drives an unknown
      for (int p = 0; p < 4; p++) begin
         wr(5'(p), 32'h0, r);
         check("latch write response", r, `RESP_OKAY);
      end
      foreach (rows[i]) begin
         wr(rows[i].idx, rows[i].wd, r);
         check("write response", r, rows[i].rsp);
         rd(rows[i].idx, d, r);
         check("read data", d, rows[i].rd);
         check("read response", r, rows[i].rsp);
      end
      // Every direction and mode code on both moded ports
      for (int p = 0; p < 2; p++) begin
         wr(p ? `IDX_PORT_D_PIN_LATCH : `IDX_PORT_C_PIN_LATCH, 32'h0F, r);
         for (int m = 0; m < 4; m++) begin
            wr(p ? `IDX_PORT_D_DIRECTION : `IDX_PORT_C_DIRECTION, m[1] ? 32'hFF : 32'h0, r);
            wr(p ? `IDX_PORT_D_PIN_CONFIG : `IDX_PORT_C_PIN_CONFIG, m[0] ? 32'hFF : 32'h0, r);
            @(posedge aclk);
            e_oe = (m == 2) ? 8'hFF : (m == 3) ? 8'hF0 : 8'h00;
            e_out = (m == 2) ? 8'h0F : 8'h00;
            e_pu = (m == 0) ? 8'hFF : 8'h00;
            check("pin enable", p ? d_oe : c_oe, e_oe);
            check("pin out", p ? d_out : c_out, e_out);
            check("pull-up", p ? d_pu : c_pu, e_pu);
            if (m[1]) begin
               rd(p ? `IDX_PORT_D_PIN_LATCH : `IDX_PORT_C_PIN_LATCH, d, r);
               check("output read", d, 32'h0F);
            end
         end
      end
      // Input read, then mixed directions on port A
      wr(`IDX_PORT_A_DIRECTION, 32'h0, r);
      wr(`IDX_PORT_A_PIN_LATCH, 32'h3C, r);
      ext_en <= 32'h000000FF;
      ext_val <= 32'h0000005A;
      repeat (8) @(posedge aclk);
      rd(`IDX_PORT_A_PIN_LATCH, d, r);
      check("input read", d, 32'h5A);
      check("input enable", a_oe, 32'h0);
      wr(`IDX_PORT_A_DIRECTION, 32'hF0, r);
      ext_en <= 32'h0000000F;
      repeat (8) @(posedge aclk);
      rd(`IDX_PORT_A_PIN_LATCH, d, r);
      check("mixed read", d, 32'h3A);
      check("mixed out", a_out, 32'h30);
      check("mixed enable", a_oe, 32'hF0);
      // Byte lane zero off leaves the register alone
      wstrb <= 4'hE;
      wr(`IDX_PORT_A_DIRECTION, 32'hFF, r);
      check("lane-off response", r, `RESP_OKAY);
      wstrb <= 4'hF;
      rd(`IDX_PORT_A_DIRECTION, d, r);
      check("lane-off direction", d, 32'hF0);
      // Shared analogue port with converter on
      g_in <= 4'h9;
      wr(`IDX_CONVERTER_STATUS_CONTROL, 32'h20, r);
      repeat (8) @(posedge aclk);
      check("converter enable", conv_en, 32'h1);
      rd(`IDX_ANALOG_PORT_INPUT, d, r);
      check("shared read", d, 32'h9);
      wr(`IDX_ANALOG_PORT_INPUT, 32'hFF, r);
      check("shared write response", r, `RESP_OKAY);
      rd(`IDX_ANALOG_PORT_INPUT, d, r);
      check("shared after write", d, 32'h9);
      // Latch survives a reset in mid-run
      wr(`IDX_PORT_B_PIN_LATCH, 32'hC3, r);
      do_reset();
      rd(`IDX_PORT_B_DIRECTION, d, r);
      check("direction after reset", d, 32'h0);
      check("converter after reset", conv_en, 32'h0);
      wr(`IDX_PORT_B_DIRECTION, 32'hFF, r);
      rd(`IDX_PORT_B_PIN_LATCH, d, r);
      check("kept latch", d, 32'hC3);
      check("kept latch out", b_out, 32'hC3);
      close_out();
   end
endmodule
`default_nettype wire
